// ==== rtl/field_threshold_regulator_pkg.sv ====
// Contract
// - peer detect deactivation level: bits 6:4 of threshold register, resets to 011.
// - peer level codes map monotonically, 000 is 75 mVpp, 111 is 800 mVpp.
// - collision level bits 3:0, reset 0011; msb clear 75..800, set 25..250 mVpp.
// - driver transient ratio read-only at bits 7:4 of timing display register.
// - timing class 3 bits: slow, medium slow, nominal, medium fast, 1xx fast.
// - source bit 7 low: adjust command result; high: externally written code.
// - external regulator code bits 6:3 of regulator control register, resets zero.
// - five volt mode: digital and analog regulators fixed at 3.4 V.
// - 3.3 V mode: digital and analog regulators follow rf driver regulator.
// - measure supply select: main, analog, digital, rf, am; 101..111 reserved.
package field_threshold_regulator_pkg;
  // ******************************
  // register map
  // ******************************
  localparam logic [5:0] IDX_DEACT_THR = 6'h2b;
  localparam logic [5:0] IDX_REG_CTL = 6'h2c;
  localparam logic [5:0] IDX_SPACE_SEL = 6'h30;
  localparam int ADDR_W = 12;
  localparam logic [2:0] PEER_RST = 3'h3;
  localparam logic [3:0] CA_RST = 4'h3;
  localparam logic [3:0] REGE_RST = 4'h0;
  localparam logic [2:0] MPSV_RST = 3'h0;
  localparam int PEER_LSB = 4;
  localparam int CA_LSB = 0;
  localparam int RATIO_LSB = 4;
  localparam int REG_S_BIT = 7;
  localparam int REGE_LSB = 3;
  localparam int MPSV_LSB = 0;
  // ******************************
  // analog decode
  // ******************************
  localparam logic [9:0] THR_MV [8] = '{10'd75, 10'd105, 10'd150, 10'd205,
                                        10'd290, 10'd400, 10'd560, 10'd800};
  localparam logic [9:0] CA_LOW_MV [8] = '{10'd25, 10'd33, 10'd47, 10'd64,
                                           10'd90, 10'd125, 10'd175, 10'd250};
  localparam logic [12:0] REG5_BASE_MV = 13'd3600;
  localparam logic [12:0] REG33_BASE_MV = 13'd1900;
  localparam logic [12:0] REG_STEP_MV = 13'd100;
  localparam logic [12:0] DA_FIXED_5V_MV = 13'd3400;
  typedef enum logic [2:0] {
    TC_SLOW = 3'b000,
    TC_MED_SLOW = 3'b001,
    TC_NOMINAL = 3'b010,
    TC_MED_FAST = 3'b011,
    TC_FAST = 3'b100
  } timing_class_t;
  typedef enum logic [2:0] {
    MS_MAIN = 3'b000,
    MS_ANALOG = 3'b001,
    MS_DIGITAL = 3'b010,
    MS_RF = 3'b011,
    MS_AM = 3'b100
  } meas_supply_t;
  localparam logic [2:0] MS_RSVD_FIRST = 3'b101;
  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [2:0] peer_detect_deact_level;
    logic [3:0] collision_avoid_deact_level;
    logic [9:0] peer_mv;
    logic [9:0] ca_mv;
    timing_class_t timing_class;
    logic reg_from_ext;
    logic [3:0] rf_reg_code;
    logic [12:0] rf_reg_mv;
    logic [12:0] da_reg_mv;
    logic [2:0] meas_sel;
    logic meas_sel_valid;
  } ana_out_t;
endpackage : field_threshold_regulator_pkg

// ==== rtl/field_threshold_regulator_regs.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module field_threshold_regulator_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire field_threshold_regulator_pkg::apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [3:0] i_drv_ratio,
  input wire logic [2:0] i_drv_timing,
  input wire logic [3:0] i_adj_reg_result,
  input wire logic i_supply_5v_mode,
  output field_threshold_regulator_pkg::ana_out_t o_ana
);
  // ******************************
  // helpers
  // ******************************
  function automatic logic addr_hit(input logic [11:0] a, input logic [5:0] idx);
    addr_hit = (a[1:0] == 2'h0) && (a[7:2] == idx) && (a[11:8] == 4'h0);
  endfunction : addr_hit

  function automatic logic [9:0] thr_mv(input logic [2:0] code, input logic low_range);
    thr_mv = low_range ? field_threshold_regulator_pkg::CA_LOW_MV[code]
                       : field_threshold_regulator_pkg::THR_MV[code];
  endfunction : thr_mv

  function automatic logic [12:0] reg_mv(input logic [3:0] code, input logic five_v);
    logic [12:0] base;
    base = five_v ? field_threshold_regulator_pkg::REG5_BASE_MV
                  : field_threshold_regulator_pkg::REG33_BASE_MV;
    reg_mv = base + 13'(code * field_threshold_regulator_pkg::REG_STEP_MV);
  endfunction : reg_mv

  // ******************************
  // pin synchronisers
  // ******************************
  logic [11:0] sync1_ff;
  logic [11:0] sync2_ff;
  logic [3:0] ratio_s;
  logic [2:0] timing_s;
  logic [3:0] adj_s;
  logic five_s;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= 12'h000;
      sync2_ff <= 12'h000;
    end else if (i_ce) begin
      sync1_ff <= {i_drv_ratio, i_drv_timing, i_adj_reg_result, i_supply_5v_mode};
      sync2_ff <= sync1_ff;
    end
  end

  assign ratio_s = sync2_ff[11:8];
  assign timing_s = sync2_ff[7:5];
  assign adj_s = sync2_ff[4:1];
  assign five_s = sync2_ff[0];

  // ******************************
  // apb decode
  // ******************************
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic space_b_ff;
  logic acc;
  logic ans;
  logic done;
  logic hit_thr;
  logic hit_ctl;
  logic hit_spc;
  logic bad;
  logic wr_ok;
  logic [31:0] rd_word;
  logic [7:0] rd_deact;
  logic [7:0] rd_tdisp;
  logic [7:0] rd_regctl;

  assign acc = i_apb.psel && i_apb.penable;
  assign ans = acc && !pready_ff;
  assign done = acc && pready_ff;
  assign hit_thr = addr_hit(i_apb.paddr, field_threshold_regulator_pkg::IDX_DEACT_THR);
  assign hit_ctl = addr_hit(i_apb.paddr, field_threshold_regulator_pkg::IDX_REG_CTL);
  assign hit_spc = addr_hit(i_apb.paddr, field_threshold_regulator_pkg::IDX_SPACE_SEL);
  // space b: 2b is read-only display, 2c belongs to another block
  assign bad = !(hit_thr || hit_ctl || hit_spc)
               || (space_b_ff && hit_ctl)
               || (space_b_ff && hit_thr && i_apb.pwrite);
  assign wr_ok = i_ce && done && i_apb.pwrite && !bad;

  // ******************************
  // fields
  // ******************************
  logic [2:0] peer_ff;
  logic [3:0] ca_ff;
  logic reg_s_ff;
  logic [3:0] rege_ff;
  logic [2:0] mpsv_ff;
  logic wr_thr;
  logic wr_ctl;

  assign wr_thr = wr_ok && hit_thr;
  assign wr_ctl = wr_ok && hit_ctl;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      peer_ff <= field_threshold_regulator_pkg::PEER_RST;
      ca_ff <= field_threshold_regulator_pkg::CA_RST;
    end else if (wr_thr) begin
      peer_ff <= i_apb.pwdata[field_threshold_regulator_pkg::PEER_LSB +: 3];
      ca_ff <= i_apb.pwdata[field_threshold_regulator_pkg::CA_LSB +: 4];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_s_ff <= 1'b0;
      rege_ff <= field_threshold_regulator_pkg::REGE_RST;
      mpsv_ff <= field_threshold_regulator_pkg::MPSV_RST;
    end else if (wr_ctl) begin
      reg_s_ff <= i_apb.pwdata[field_threshold_regulator_pkg::REG_S_BIT];
      rege_ff <= i_apb.pwdata[field_threshold_regulator_pkg::REGE_LSB +: 4];
      mpsv_ff <= i_apb.pwdata[field_threshold_regulator_pkg::MPSV_LSB +: 3];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      space_b_ff <= 1'b0;
    end else if (wr_ok && hit_spc) begin
      space_b_ff <= i_apb.pwdata[0];
    end
  end

  // ******************************
  // read back
  // ******************************
  // unused bits stay zero
  assign rd_deact = {1'b0, peer_ff, ca_ff};
  assign rd_tdisp = {ratio_s, 1'b0, timing_s};
  assign rd_regctl = {reg_s_ff, rege_ff, mpsv_ff};
  assign rd_word = bad ? 32'h0000_0000
                 : hit_spc ? {31'h0000_0000, space_b_ff}
                 : hit_ctl ? {24'h00_0000, rd_regctl}
                 : space_b_ff ? {24'h00_0000, rd_tdisp}
                 : {24'h00_0000, rd_deact};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      pready_ff <= ans;
      pslverr_ff <= ans && bad;
      prdata_ff <= ans ? rd_word : 32'h0000_0000;
    end
  end

  // ******************************
  // analog side
  // ******************************
  field_threshold_regulator_pkg::ana_out_t ana_ff;
  field_threshold_regulator_pkg::ana_out_t nxt_ana;
  field_threshold_regulator_pkg::timing_class_t nxt_tc;
  logic [3:0] nxt_rf_code;
  logic [12:0] nxt_rf_mv;

  assign nxt_tc = timing_s[2] ? field_threshold_regulator_pkg::TC_FAST
                : field_threshold_regulator_pkg::timing_class_t'(timing_s);
  assign nxt_rf_code = reg_s_ff ? rege_ff : adj_s;
  assign nxt_rf_mv = reg_mv(nxt_rf_code, five_s);

  always_comb begin
    nxt_ana.peer_detect_deact_level = peer_ff;
    nxt_ana.collision_avoid_deact_level = ca_ff;
    nxt_ana.peer_mv = thr_mv(peer_ff, 1'b0);
    nxt_ana.ca_mv = thr_mv(ca_ff[2:0], ca_ff[3]);
    nxt_ana.timing_class = nxt_tc;
    nxt_ana.reg_from_ext = reg_s_ff;
    nxt_ana.rf_reg_code = nxt_rf_code;
    nxt_ana.rf_reg_mv = nxt_rf_mv;
    nxt_ana.da_reg_mv = five_s ? field_threshold_regulator_pkg::DA_FIXED_5V_MV
                               : nxt_rf_mv;
    nxt_ana.meas_sel = mpsv_ff;
    nxt_ana.meas_sel_valid = mpsv_ff < field_threshold_regulator_pkg::MS_RSVD_FIRST;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ana_ff <= '0;
    end else if (i_ce) begin
      ana_ff <= nxt_ana;
    end
  end

  assign o_ana = ana_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  peer_write_a: assert property (wr_thr |=> peer_ff == $past(i_apb.pwdata[6:4]))
    else $error("peer level not stored");
  peer_span_a: assert property ((i_ce && peer_ff == 3'h7) |=> o_ana.peer_mv == 10'd800)
    else $error("peer top level not 800 mV");
  ca_range_a: assert property ((i_ce && ca_ff[3]) |=> o_ana.ca_mv <= 10'd250)
    else $error("collision high range exceeds 250 mV");
  ro_write_a: assert property ((i_ce && ans && space_b_ff && hit_thr && i_apb.pwrite) |=> o_pslverr)
    else $error("display write not refused");
  timing_fast_a: assert property ((i_ce && timing_s[2]) |=> o_ana.timing_class == 3'b100)
    else $error("1xx timing not fast");
  reg_source_a: assert property ((i_ce && !reg_s_ff) |=> o_ana.rf_reg_code == $past(adj_s))
    else $error("adjust result not used");
  rege_write_a: assert property (wr_ctl |=> rege_ff == $past(i_apb.pwdata[6:3]))
    else $error("external code not stored");
  da_fixed_a: assert property ((i_ce && five_s) |=> o_ana.da_reg_mv == 13'd3400)
    else $error("5 V mode regulators not 3.4 V");
  da_track_a: assert property ((i_ce && !five_s) |=> o_ana.da_reg_mv == o_ana.rf_reg_mv)
    else $error("3.3 V mode regulators not tracking rf");
  meas_rsvd_a: assert property ((i_ce && mpsv_ff[2] && mpsv_ff[1:0] != 2'h0) |=> !o_ana.meas_sel_valid)
    else $error("reserved supply select marked valid");
  rsvd_zero_a: assert property ((i_ce && ans && !space_b_ff && hit_thr) |=> o_prdata[31:7] == 25'h0)
    else $error("reserved bits not zero");

  // ******************************
  // field checks
  // ******************************
  ca_write_a: assert property (wr_thr |=> ca_ff == $past(i_apb.pwdata[3:0]))
    else $error("collision level not stored");
  src_write_a: assert property (wr_ctl |=> reg_s_ff == $past(i_apb.pwdata[7]))
    else $error("source select not stored");
  meas_write_a: assert property (wr_ctl |=> mpsv_ff == $past(i_apb.pwdata[2:0]))
    else $error("supply select not stored");
  space_write_a: assert property ((wr_ok && hit_spc) |=> space_b_ff == $past(i_apb.pwdata[0]))
    else $error("space select not stored");
  peer_floor_a: assert property ((i_ce && peer_ff == 3'h0) |=> o_ana.peer_mv == 10'd75)
    else $error("peer bottom level not 75 mV");
  ca_top_a: assert property ((i_ce && ca_ff == 4'h7) |=> o_ana.ca_mv == 10'd800)
    else $error("collision top level not 800 mV");
  ca_floor_a: assert property ((i_ce && ca_ff == 4'h8) |=> o_ana.ca_mv == 10'd25)
    else $error("collision low floor not 25 mV");
  reg_ext_a: assert property ((i_ce && reg_s_ff) |=> o_ana.rf_reg_code == $past(rege_ff))
    else $error("external code not used");
  rf_top_a: assert property ((i_ce && !five_s && nxt_rf_code == 4'hf) |=> o_ana.rf_reg_mv == 13'd3400)
    else $error("3.3 V top code not 3.4 V");
  rf_base_a: assert property ((i_ce && five_s && nxt_rf_code == 4'h0) |=> o_ana.rf_reg_mv == 13'd3600)
    else $error("5 V bottom code not 3.6 V");
  meas_valid_a: assert property ((i_ce && !mpsv_ff[2]) |=> o_ana.meas_sel_valid)
    else $error("supply select wrongly reserved");
  refuse_keep_a: assert property ((done && bad)
    |=> $stable({peer_ff, ca_ff, reg_s_ff, rege_ff, mpsv_ff, space_b_ff}))
    else $error("refused write changed a field");

  // ******************************
  // read back checks
  // ******************************
  ratio_read_a: assert property ((i_ce && ans && space_b_ff && hit_thr && !i_apb.pwrite)
    |=> o_prdata[7:4] == $past(ratio_s))
    else $error("driver ratio not shown");
  timing_read_a: assert property ((i_ce && ans && space_b_ff && hit_thr && !i_apb.pwrite)
    |=> o_prdata[2:0] == $past(timing_s))
    else $error("driver timing not shown");
  disp_rsvd_a: assert property ((i_ce && ans && space_b_ff && hit_thr) |=> !o_prdata[3])
    else $error("display reserved bit not zero");
  ctl_read_a: assert property ((i_ce && ans && !space_b_ff && hit_ctl && !i_apb.pwrite)
    |=> o_prdata[7:0] == $past({reg_s_ff, rege_ff, mpsv_ff}))
    else $error("regulator control not read back");
  err_data_a: assert property ((i_ce && ans && bad) |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("refused access returned data");
  ctl_space_b_a: assert property ((i_ce && ans && space_b_ff && hit_ctl) |=> o_pslverr)
    else $error("space b control access not refused");
  bad_align_a: assert property ((i_ce && ans && i_apb.paddr[1:0] != 2'h0) |=> o_pslverr)
    else $error("misaligned access not refused");

  // ******************************
  // handshake and clock enable
  // ******************************
  ready_wait_a: assert property ((i_ce && ans) |=> o_pready)
    else $error("no answer after access edge");
  ready_pulse_a: assert property ((i_ce && o_pready) |=> !o_pready)
    else $error("ready held past one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error flagged without ready");
  idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  freeze_regs_a: assert property (!i_ce |=> $stable({peer_ff, ca_ff, reg_s_ff, rege_ff, mpsv_ff, space_b_ff}))
    else $error("fields changed while disabled");
  freeze_bus_a: assert property (!i_ce |=> $stable({pready_ff, pslverr_ff, prdata_ff}))
    else $error("bus answer changed while disabled");
  freeze_ana_a: assert property (!i_ce |=> $stable(ana_ff) && $stable(sync2_ff))
    else $error("analog side changed while disabled");

  thr_write_c: cover property (wr_thr);
  disp_read_c: cover property (ans && space_b_ff && hit_thr && !i_apb.pwrite);
  ext_mode_c: cover property (wr_ctl && i_apb.pwdata[7]);
  err_c: cover property (ans && bad);
  ce_resume_c: cover property (!i_ce ##1 i_ce);
endmodule : field_threshold_regulator_regs

// ==== dv/field_threshold_regulator_regs_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, (ex), (got)); end end
module field_threshold_regulator_regs_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ce = 1'b1;
  field_threshold_regulator_pkg::apb_req_t req = '0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [3:0] ratio = 4'h0;
  logic [3:0] adj = 4'h0;
  logic [2:0] tim = 3'h0;
  logic mode5 = 1'b0;
  field_threshold_regulator_pkg::ana_out_t o_ana;
  logic [33:0] q[$];
  logic [9:0] pk [8] = '{10'd75, 10'd105, 10'd150, 10'd205, 10'd290, 10'd400, 10'd560, 10'd800};
  logic [9:0] lo [8] = '{10'd25, 10'd33, 10'd47, 10'd64, 10'd90, 10'd125, 10'd175, 10'd250};
  int errors = 0;
  int checked = 0;
  int seed = 32'h741af5af;
  logic [31:0] r;
  logic [3:0] c;
  logic [12:0] mv;

  field_threshold_regulator_regs DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_apb(req), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_drv_ratio(ratio), .i_drv_timing(tim), .i_adj_reg_result(adj),
    .i_supply_5v_mode(mode5), .o_ana(o_ana));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // ******************************
  // apb master and result monitor
  // ******************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] ex);
    q.push_back(ex);
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    req <= '0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {1'b0, err, 32'h0});
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b0, a, 32'h0, {1'b1, err, d});
  endtask : rd

  task settle;
    repeat (4) @(posedge i_clk);
  endtask : settle

  always @(posedge i_clk) begin
    logic [33:0] e;
    if (o_pready === 1'b1) begin
      e = q.pop_front();
      `CHK("pslverr", e[32], o_pslverr)
      if (e[33]) `CHK("prdata", e[31:0], o_prdata)
    end
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    tally_and_finish();
  end

  // ******************************
  // tests
  // ******************************
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    rd(12'hac, 32'h33, 1'b0);
    rd(12'hb0, 32'h0, 1'b0);
    `CHK("peer_mv", 10'd205, o_ana.peer_mv)
    `CHK("ca_mv", 10'd205, o_ana.ca_mv)
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wr(12'hac, {24'h0, r[0], i[2:0], i[3:0]}, 1'b0);
      rd(12'hac, {24'h0, 1'b0, i[2:0], i[3:0]}, 1'b0);
      settle();
      `CHK("peer_lvl", i[2:0], o_ana.peer_detect_deact_level)
      `CHK("peer_mv", pk[i[2:0]], o_ana.peer_mv)
      `CHK("ca_lvl", i[3:0], o_ana.collision_avoid_deact_level)
      `CHK("ca_mv", i[3] ? lo[i[2:0]] : pk[i[2:0]], o_ana.ca_mv)
    end
    $display("test thresholds done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      mode5 <= r[8];
      adj <= r[12:9];
      wr(12'hb0, {24'h0, r[7:3], i[2:0]}, 1'b0);
      rd(12'hb0, {24'h0, r[7:3], i[2:0]}, 1'b0);
      settle();
      c = r[7] ? r[6:3] : r[12:9];
      mv = (r[8] ? 13'd3600 : 13'd1900) + 13'd100 * {9'h0, c};
      `CHK("from_ext", r[7], o_ana.reg_from_ext)
      `CHK("reg_code", c, o_ana.rf_reg_code)
      `CHK("rf_mv", mv, o_ana.rf_reg_mv)
      `CHK("da_mv", r[8] ? 13'd3400 : mv, o_ana.da_reg_mv)
      `CHK("meas_sel", i[2:0], o_ana.meas_sel)
      `CHK("meas_ok", i[2:0] < 3'd5, o_ana.meas_sel_valid)
    end
    $display("test regulator done");
    wr(12'hc0, 32'h1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      ratio <= r[3:0];
      tim <= i[2:0];
      settle();
      rd(12'hac, {24'h0, r[3:0], 1'b0, i[2:0]}, 1'b0);
      `CHK("t_class", i[2] ? 3'b100 : i[2:0], o_ana.timing_class)
    end
    wr(12'hac, 32'h0, 1'b1);
    rd(12'hb0, 32'h0, 1'b1);
    wr(12'hc0, 32'h0, 1'b0);
    rd(12'hac, 32'h7f, 1'b0);
    $display("test display done");
    rd(12'h1ac, 32'h0, 1'b1);
    wr(12'had, 32'h11, 1'b1);
    rd(12'h0, 32'h0, 1'b1);
    rd(12'hac, 32'h7f, 1'b0);
    $display("test errors done");
    wr(12'hb0, 32'h0, 1'b0);
    r = $random(seed);
    adj <= r[3:0];
    settle();
    `CHK("adj_code", r[3:0], o_ana.rf_reg_code)
    // clock enable low: analog side and bus answer must both wait
    ce <= 1'b0;
    adj <= ~r[3:0];
    fork
      rd(12'hac, 32'h7f, 1'b0);
      begin
        repeat (8) @(posedge i_clk);
        `CHK("frozen_code", r[3:0], o_ana.rf_reg_code)
        `CHK("frozen_ready", 1'b0, o_pready)
        ce <= 1'b1;
      end
    join
    settle();
    `CHK("resumed_code", ~r[3:0], o_ana.rf_reg_code)
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule : field_threshold_regulator_regs_test
